// ===== design/stt_map.svh
// Purpose: Register offsets, fields and reset values of the tick timer
// Assumes: Word-aligned classic Wishbone slave, 32-bit data
// Notes:   Definitions only
`ifndef STT_MAP_SVH
`define STT_MAP_SVH

`define STT_AW            6
`define STT_OFF_CTRL      6'h00
`define STT_OFF_RELOAD    6'h04
`define STT_OFF_LIVE      6'h08
`define STT_OFF_IRQ_STAT  6'h0C
`define STT_OFF_IRQ_MASK  6'h10

`define STT_CNT_W         24
`define STT_BIT_ENABLE    0
`define STT_BIT_IRQEN     1
`define STT_BIT_CLKSRC    2
`define STT_BIT_WRAP      16

`define STT_RST_CTRL      3'h0
`define STT_RST_RELOAD    24'h00_0000
`define STT_RST_LIVE      24'h00_0000
`define STT_IRQ_W         1

`endif

// ===== design/stt_pkg.sv
// Purpose: Types of the tick timer
// Assumes: Nothing
// Notes:   Constants live in stt_map.svh
`default_nettype none
package stt_pkg;
  typedef enum logic [1:0] {
    STT_IDLE,
    STT_ACK
  } stt_bus_state_t;
endpackage : stt_pkg
`default_nettype wire

// ===== design/stt_down_counter.sv
// Purpose: Reloading down counter of the tick timer
// Assumes: Single clock, reference tick every clock
// Notes:   Write-clear takes priority over counting
`default_nettype none
`include "stt_map.svh"
module stt_down_counter #(
  parameter int CNT_W = `STT_CNT_W
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Control
  input  wire logic             enable,
  input  wire logic             halted,
  input  wire logic             clear,
  input  wire logic [CNT_W-1:0] reload,
  // Status
  output logic      [CNT_W-1:0] count,
  output logic                  wrap
);
  initial begin
    if (CNT_W < 1 || CNT_W > 24) $error("CNT_W out of range");
  end

  logic [CNT_W-1:0] count_q;
  logic [CNT_W-1:0] count_d;
  logic             wrap_d;

  always_comb begin
    count_d = count_q;
    wrap_d  = 1'b0;
    if (clear) begin
      count_d = '0;
    end else if (enable && !halted) begin
      if (count_q == '0) begin
        count_d = reload;
      end else begin
        count_d = count_q - 1'b1;
        wrap_d  = (count_q == {{(CNT_W-1){1'b0}}, 1'b1});
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count_q <= '0;
      wrap    <= 1'b0;
    end else begin
      count_q <= count_d;
      wrap    <= wrap_d;
    end
  end

  assign count = count_q;
endmodule : stt_down_counter
`default_nettype wire

// ===== design/stt_timer.sv
// Purpose: System tick timer with live count register on Wishbone
// Assumes: Classic Wishbone, single clock at 20 MHz
// Notes:   Ack one cycle after a request, never waits
//
// The register offsets and the Wishbone slave port were chosen for this implementation.
`default_nettype none
`include "stt_map.svh"
// Notes on behaviour
// - Read returns live count, no latching
// - Any write to live count zeroes it
// - That write also clears wrap flag
// - Upper eight bits reserved, read zero
// - No calibration register exists
// - Count down, reload after zero, continue
// - Zero sets wrap flag; read clears it
// - Wrap with irq enable pends tick exception
// - Counter holds while core halted
module stt_timer
  import stt_pkg::*;
#(
  parameter int CNT_W = `STT_CNT_W
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // Core state
  input  wire logic        core_halted,
  // Interrupts
  output logic             tick_pend,
  output logic             irq
);
  initial begin
    if (CNT_W != `STT_CNT_W) $error("CNT_W must be 24");
  end

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  stt_bus_state_t st_q;
  stt_bus_state_t st_d;
  logic           req;
  logic           wr_acc;
  logic           rd_acc;
  logic           hit;

  assign req    = cyc_i && stb_i && (st_q == STT_IDLE);
  assign hit    = (adr_i == `STT_OFF_CTRL) || (adr_i == `STT_OFF_RELOAD) ||
                  (adr_i == `STT_OFF_LIVE) || (adr_i == `STT_OFF_IRQ_STAT) ||
                  (adr_i == `STT_OFF_IRQ_MASK);
  assign wr_acc = req && we_i && hit;
  assign rd_acc = req && !we_i && hit;

  function automatic logic is_wr(input logic [5:0] a, input logic [5:0] off);
    is_wr = (a == off);
  endfunction : is_wr

  always_comb begin
    case (st_q)
      STT_IDLE: st_d = req ? STT_ACK : STT_IDLE;
      STT_ACK:  st_d = STT_IDLE;
      default:  st_d = STT_IDLE;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [2:0]       ctrl_q;
  logic [2:0]       ctrl_d;
  logic [CNT_W-1:0] reload_q;
  logic [CNT_W-1:0] reload_d;
  logic             wrap_flag_q;
  logic             wrap_flag_d;
  logic             ist_q;
  logic             ist_d;
  logic             imask_q;
  logic             imask_d;
  logic             pend_q;
  logic             pend_d;
  logic [31:0]      rdata_d;
  logic [31:0]      rdata_q;
  logic             err_d;
  logic             err_q;
  logic             live_clr;
  logic             ctrl_rd;
  logic [CNT_W-1:0] count;
  logic             wrap;

  assign live_clr = wr_acc && is_wr(adr_i, `STT_OFF_LIVE);
  assign ctrl_rd  = rd_acc && is_wr(adr_i, `STT_OFF_CTRL);

  stt_down_counter #(
    .CNT_W (CNT_W)
  ) u_cnt (
    .clk    (clk),
    .resetn (resetn),
    .enable (ctrl_q[`STT_BIT_ENABLE]),
    .halted (core_halted),
    .clear  (live_clr),
    .reload (reload_q),
    .count  (count),
    .wrap   (wrap)
  );

  always_comb begin
    ctrl_d      = ctrl_q;
    reload_d    = reload_q;
    imask_d     = imask_q;
    ist_d       = ist_q;
    wrap_flag_d = wrap_flag_q;
    rdata_d     = rdata_q;
    err_d       = req && !hit;
    if (wr_acc && sel_i[0] && is_wr(adr_i, `STT_OFF_CTRL)) begin
      ctrl_d = dat_i[2:0];
    end
    if (wr_acc && is_wr(adr_i, `STT_OFF_RELOAD)) begin
      if (sel_i[0]) reload_d[7:0]   = dat_i[7:0];
      if (sel_i[1]) reload_d[15:8]  = dat_i[15:8];
      if (sel_i[2]) reload_d[23:16] = dat_i[23:16];
    end
    if (wr_acc && sel_i[0] && is_wr(adr_i, `STT_OFF_IRQ_MASK)) begin
      imask_d = dat_i[0];
    end
    if (wr_acc && sel_i[0] && is_wr(adr_i, `STT_OFF_IRQ_STAT) && dat_i[0]) begin
      ist_d = 1'b0;
    end
    if (live_clr || ctrl_rd) begin
      wrap_flag_d = 1'b0;
    end
    if (wrap) begin
      wrap_flag_d = 1'b1;
      ist_d       = 1'b1;
    end
    if (rd_acc) begin
      rdata_d = 32'h0000_0000;
      case (adr_i)
        `STT_OFF_CTRL: begin
          rdata_d[2:0]            = ctrl_q;
          rdata_d[`STT_BIT_WRAP]  = wrap_flag_q;
        end
        `STT_OFF_RELOAD:   rdata_d[CNT_W-1:0] = reload_q;
        `STT_OFF_LIVE:     rdata_d[CNT_W-1:0] = count;
        `STT_OFF_IRQ_STAT: rdata_d[0] = ist_q;
        `STT_OFF_IRQ_MASK: rdata_d[0] = imask_q;
        default:           rdata_d = 32'h0000_0000;
      endcase
    end
    // pend only when enabled; clear cannot pend
    pend_d = wrap && ctrl_q[`STT_BIT_IRQEN];
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q        <= STT_IDLE;
      ctrl_q      <= `STT_RST_CTRL;
      reload_q    <= `STT_RST_RELOAD;
      wrap_flag_q <= 1'b0;
      ist_q       <= 1'b0;
      imask_q     <= 1'b0;
      pend_q      <= 1'b0;
      rdata_q     <= 32'h0000_0000;
      err_q       <= 1'b0;
    end else begin
      st_q        <= st_d;
      ctrl_q      <= ctrl_d;
      reload_q    <= reload_d;
      wrap_flag_q <= wrap_flag_d;
      ist_q       <= ist_d;
      imask_q     <= imask_d;
      pend_q      <= pend_d;
      rdata_q     <= rdata_d;
      err_q       <= err_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Ack and err gated by live request so dropped cycles end cleanly
  assign ack_o     = (st_q == STT_ACK) && !err_q && cyc_i && stb_i;
  assign err_o     = (st_q == STT_ACK) && err_q && cyc_i && stb_i;
  assign dat_o     = rdata_q;
  assign tick_pend = pend_q;
  assign irq       = ist_q && imask_q;
endmodule : stt_timer
`default_nettype wire

// ===== dv/stt_timer_assertions.sv
// Purpose: Port checker of stt_timer
// Assumes: Ack one cycle after a request
// Notes:   Bound from the bench top
`default_nettype none
module stt_timer_assertions #(
  parameter int CNT_W = 24
) (
  input wire logic        clk, resetn, cyc_i, stb_i, we_i,
  input wire logic [5:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i, dat_o,
  input wire logic        ack_o, err_o, core_halted, tick_pend, irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic req;
  assign req = cyc_i && stb_i && !ack_o && !err_o;
  AST_ANSWER: assert property (req |=> ack_o || err_o) else $error("no answer");
  AST_ONE_ACK: assert property (ack_o |=> !ack_o) else $error("long ack");
  AST_ACK_REQ:
    assert property ((ack_o || err_o) |-> cyc_i && stb_i && !(ack_o && err_o))
    else $error("stray ack");
  AST_RSV_ZERO: assert property (req && !we_i && adr_i == 6'h08 |=> dat_o[31:24] == 8'h00)
    else $error("upper bits set");
  AST_NO_CAL: assert property (req && adr_i >= 6'h14 |=> err_o && !ack_o)
    else $error("unmapped hit");
  AST_READ_HOLD: assert property (!(req && !we_i) |=> $stable(dat_o))
    else $error("data moved");
  AST_PEND_GAP: assert property (tick_pend |=> !tick_pend) else $error("long pend");
  AST_HALT_HOLD: assert property (core_halted [*3] |-> !tick_pend)
    else $error("pend while halted");
  cover property (tick_pend);
  cover property (err_o);
  cover property (req && we_i && adr_i == 6'h08);
endmodule : stt_timer_assertions
`default_nettype wire

// ===== dv/stt_timer_test.sv
// Purpose: Self-checking bench of stt_timer
// Assumes: Ack one cycle after a request
// Notes:   Short reloads keep the run brief
`default_nettype none
module stt_timer_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk, resetn, cyc, stb, we, halt, ack, err, pend, irq, er;
  logic [5:0]  adr;
  logic [3:0]  sel;
  logic [31:0] dat, dat_o, rd, r1;
  int          error_cnt, total_checks, per, cnt, pend_cnt, tmo, n, pc;
  int          seed = 32'he0bc_7b47;
  stt_timer dut (.clk(clk), .resetn(resetn), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .sel_i(sel), .dat_i(dat), .dat_o(dat_o), .ack_o(ack), .err_o(err),
    .core_halted(halt), .tick_pend(pend), .irq(irq));
  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  // Off-edge watch avoids racing the pulse
  always @(negedge clk) begin
    cnt <= cnt + 1;
    tmo <= tmo + 1;
    if (pend === 1'b1) begin
      per <= cnt;
      cnt <= 1;
      pend_cnt <= pend_cnt + 1;
    end
    if (tmo == 20000) begin
      error_cnt++;
      results();
    end
  end
  task automatic chk(input string nm, input logic [31:0] s, e);
    total_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("ERROR %s exp %h seen %h", nm, e, s);
    end
  endtask : chk
  function automatic int exp_period(input int r);
    return r + 1;
  endfunction : exp_period
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, dat} <= {2'b11, w, a, d};
    // Ack and data read at the edge, before its own updates land
    do @(posedge clk); while (!(ack || err));
    rd = dat_o;
    er = err;
    {cyc, stb} <= 2'b00;
  endtask : wb
  task automatic results;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : results
  initial begin
    {resetn, cyc, stb, we, halt, adr, dat} = '0;
    sel = 4'hf;
    repeat (20) @(posedge clk);
    resetn <= 1;
    wb(1, 6'h10, 32'h0000_0001);
    for (int i = 0; i < 3; i++) begin
      n = (i == 0) ? 1 : 3 + $unsigned($random(seed)) % 30;
      wb(1, 6'h00, 32'h0000_0000);
      wb(1, 6'h08, $random(seed) & 32'h00ff_ffff);
      wb(1, 6'h04, n);
      wb(1, 6'h00, 32'h0000_0003);
      repeat (3 * n + 8) @(posedge clk);
      @(negedge clk);
      chk("period", per, exp_period(n));
      chk("irq", irq, 1);
    end
    halt <= 1;
    wb(0, 6'h08, 0);
    r1 = rd;
    chk("upper", rd[31:24], 0);
    wb(0, 6'h08, 0);
    chk("halted", rd, r1);
    halt <= 0;
    wb(0, 6'h08, 0);
    chk("live", rd === r1, 0);
    wb(0, 6'h0c, 0);
    chk("stat", rd, 32'h0000_0001);
    wb(1, 6'h00, 32'h0000_0001);
    wb(1, 6'h10, 0);
    wb(1, 6'h0c, 32'h0000_0001);
    pc = pend_cnt;
    repeat (3 * n + 8) @(posedge clk);
    @(negedge clk);
    chk("no pend", pend_cnt, pc);
    chk("masked", irq, 0);
    wb(1, 6'h10, 32'h0000_0001);
    @(negedge clk);
    chk("unmasked", irq, 1);
    wb(1, 6'h00, 0);
    wb(1, 6'h0c, 32'h0000_0001);
    @(negedge clk);
    chk("cleared", irq, 0);
    wb(0, 6'h00, 0);
    chk("flag", rd[16], 1);
    wb(0, 6'h00, 0);
    chk("flag read", rd[16], 0);
    wb(1, 6'h00, 32'h0000_0001);
    repeat (2 * n) @(posedge clk);
    wb(1, 6'h00, 0);
    wb(1, 6'h08, 32'h00ff_ffff);
    wb(0, 6'h00, 0);
    chk("flag wr", rd[16], 0);
    wb(0, 6'h08, 0);
    chk("zeroed", rd, 0);
    wb(1, 6'h04, 32'h0012_3456);
    sel <= 4'h1;
    wb(1, 6'h04, 32'h00ff_ffff);
    sel <= 4'hf;
    wb(0, 6'h04, 0);
    chk("lanes", rd, 32'h0012_34ff);
    wb(1, 6'h04, 32'h0000_00c8);
    wb(1, 6'h00, 32'h0000_0003);
    pc = pend_cnt;
    wb(1, 6'h08, 0);
    repeat (5) @(posedge clk);
    chk("quiet", pend_cnt, pc);
    wb(0, 6'h14, 0);
    chk("cal slot", er, 1);
    results();
  end
endmodule : stt_timer_test
bind stt_timer stt_timer_assertions #(.CNT_W(CNT_W)) chk_a (.clk(clk), .resetn(resetn),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .core_halted(core_halted),
  .tick_pend(tick_pend), .irq(irq));
`default_nettype wire
